// >>> logic/ext_irq_and_vector_table.sv
// Purpose: external pin and pin-change interrupt logic with vector table
// Assumes: core samples irq_out, pulses irq_ack when it takes the vector
// Notes:   pins are asynchronous and pass two flip-flops before use

`timescale 1ns/1ps
`default_nettype none

module ext_irq_and_vector_table (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic [7:0]                     address,
	input  wire logic                           read,
	input  wire logic                           write,
	input  wire logic [31:0]                    writedata,
	input  wire logic [3:0]                     byteenable,
	output logic      [31:0]                    readdata,
	output logic                                waitrequest,
	input  wire logic                           ext_irq_pin,
	input  wire logic [irq_pkg::NUM_PC-1:0]     pin_change_input,
	input  wire logic [irq_pkg::NUM_PERIPH-1:0] periph_irq,
	input  wire logic                           global_irq_en,
	input  wire logic                           irq_ack,
	input  wire logic                           sleep_cmd,
	input  wire logic                           sleep_idle,
	output irq_pkg::irq_out_t                   irq_out,
	output logic                                io_clk_run,
	output logic                                wake_pulse,
	output logic                                sleep_resume,
	output logic                                reset_fetch
);
	import irq_pkg::*;

	// =========================================================
	// declarations
	logic [NUM_PC:0]        sync1_r;
	logic [NUM_PC:0]        sync2_r;
	logic [NUM_PC-1:0]      pc_prev_r;
	logic                   ext_prev_r;
	logic [CTRL_W-1:0]      ctrl_r;
	logic [G0_W-1:0]        pin_change_mask_lo_r;
	logic [G1_W-1:0]        pin_change_mask_mid_r;
	logic [G2_W-1:0]        pin_change_mask_hi_r;
	logic                   ext_irq_flag_r;
	logic [NUM_GRP-1:0]     pin_change_group_flag_r;
	logic                   waitrequest_r;
	logic [31:0]            readdata_r;
	irq_out_t               irq_out_r;
	pwr_state_t             state_r;
	logic                   idle_mode_r;
	logic [CNT_W-1:0]       startup_cnt_r;
	logic                   io_clk_run_r;
	logic                   wake_pulse_r;
	logic                   sleep_resume_r;
	logic                   booted_r;
	logic                   reset_fetch_r;

	logic [NUM_PC-1:0]      pc_now;
	logic                   ext_now;
	logic [NUM_PC-1:0]      mask_all;
	logic [NUM_PC-1:0]      pc_toggle;
	logic [NUM_GRP-1:0]     grp_hit;
	sense_t                 ext_irq_sense_select;
	logic                   ext_en;
	logic [NUM_GRP-1:0]     pin_change_group_enable;
	logic                   ext_fall;
	logic                   ext_rise;
	logic                   ext_edge_hit;
	logic                   level_mode;
	logic                   ext_level_req;
	logic [NUM_VEC-1:0]     src_req;
	logic                   any_req;
	logic [IDX_W-1:0]       sel_idx;
	logic                   bus_req;
	logic                   wr_acc;
	logic                   wr_lane0;
	logic [31:0]            rd_mux;
	logic                   ack_hit;
	logic                   ext_clr;
	logic [NUM_GRP-1:0]     grp_clr;
	logic                   ext_irq_flag_nxt;
	logic [NUM_GRP-1:0]     pin_change_group_flag_nxt;
	logic                   deep_wake;
	pwr_state_t             state_nxt;
	logic [CNT_W-1:0]       startup_cnt_nxt;
	logic                   startup_done;
	irq_out_t               irq_out_nxt;

	// =========================================================
	// helper functions

	// lowest index wins; index 0 (reset) is never an interrupt source
	function automatic logic [IDX_W-1:0] first_set(
		input logic [NUM_VEC-1:0] req
	);
		logic [IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_VEC - 1; i > 0; i--) begin
			if (req[i]) begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction : first_set

	// vectors sit two words apart from the reset vector upward
	function automatic logic [VEC_W-1:0] vec_of(
		input logic [IDX_W-1:0] idx
	);
		return VEC_RESET + VEC_W'(idx) * VEC_W'(VEC_STEP);
	endfunction : vec_of

	// =========================================================
	// pin synchronisers and captured levels

	// two flops per pin; pins read the same as inputs or outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_r <= {1'b1, {NUM_PC{1'b0}}}; // ext pin idles high
			sync2_r <= {1'b1, {NUM_PC{1'b0}}};
		end else begin
			sync1_r <= {ext_irq_pin, pin_change_input};
			sync2_r <= sync1_r;
		end
	end

	assign pc_now  = sync2_r[NUM_PC-1:0];
	assign ext_now = sync2_r[NUM_PC];

	// pin-change history runs regardless of the I/O clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pc_prev_r <= '0;
		end else begin
			pc_prev_r <= pc_now;
		end
	end

	// external edge history only advances while the I/O clock runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_prev_r <= 1'b1;
		end else if (io_clk_run_r) begin
			ext_prev_r <= ext_now;
		end
	end

	// =========================================================
	// pin change detection
	assign mask_all = {pin_change_mask_hi_r, pin_change_mask_mid_r,
		pin_change_mask_lo_r};

	// per-pin toggle, gated by its mask bit
	for (genvar i = 0; i < NUM_PC; i++) begin : g_pc
		assign pc_toggle[i] = (pc_now[i] ^ pc_prev_r[i]) & mask_all[i];
	end

	assign grp_hit[0] = |pc_toggle[G0_LO +: G0_W];
	assign grp_hit[1] = |pc_toggle[G1_LO +: G1_W];
	assign grp_hit[2] = |pc_toggle[G2_LO +: G2_W];

	// =========================================================
	// external pin sensing
	assign ext_irq_sense_select    = sense_t'(ctrl_r[SENSE_POS +: 2]);
	assign ext_en                  = ctrl_r[EXT_EN_POS];
	assign pin_change_group_enable = ctrl_r[GRP_EN_POS +: NUM_GRP];

	assign ext_fall   = io_clk_run_r & ext_prev_r & ~ext_now;
	assign ext_rise   = io_clk_run_r & ~ext_prev_r & ext_now;
	assign level_mode = (ext_irq_sense_select == SENSE_LOW);

	// sense decode: low level, any change, falling, rising
	always_comb begin
		case (ext_irq_sense_select)
			SENSE_LOW:  ext_edge_hit = 1'b0;
			SENSE_ANY:  ext_edge_hit = ext_fall | ext_rise;
			SENSE_FALL: ext_edge_hit = ext_fall;
			SENSE_RISE: ext_edge_hit = ext_rise;
			default:    ext_edge_hit = 1'b0;
		endcase
	end

	// low level is combinational on the synced pin, no clock gating
	assign ext_level_req = level_mode & ~ext_now;

	// =========================================================
	// request vector and arbitration

	// a source only reaches the table once enabled; others never vector
	assign src_req[0] = 1'b0;
	assign src_req[IDX_EXT] = global_irq_en & ext_en &
		(level_mode ? ext_level_req : ext_irq_flag_r);
	assign src_req[IDX_GRP0 +: NUM_GRP] = pin_change_group_flag_r &
		pin_change_group_enable & {NUM_GRP{global_irq_en}};
	assign src_req[IDX_PERIPH +: NUM_PERIPH] = periph_irq &
		{NUM_PERIPH{global_irq_en}};

	assign any_req = |src_req;
	assign sel_idx = first_set(src_req);

	// =========================================================
	// flag set and clear

	// the core's acknowledge clears the flag of the presented vector
	assign ack_hit = irq_ack & irq_out_r.pending;
	assign ext_clr = (ack_hit && irq_out_r.index == IDX_W'(IDX_EXT)) |
		(wr_lane0 && address == REG_FLAG && writedata[FLAG_EXT]);

	for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
		assign grp_clr[g] =
			(ack_hit && irq_out_r.index == IDX_W'(IDX_GRP0 + g)) |
			(wr_lane0 && address == REG_FLAG && writedata[FLAG_GRP + g]);
	end

	// a new event wins over a clear in the same cycle
	assign ext_irq_flag_nxt = level_mode ? 1'b0 :
		(ext_edge_hit | (ext_irq_flag_r & ~ext_clr));
	assign pin_change_group_flag_nxt = grp_hit |
		(pin_change_group_flag_r & ~grp_clr);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_irq_flag_r          <= 1'b0;
			pin_change_group_flag_r <= '0;
		end else begin
			ext_irq_flag_r          <= ext_irq_flag_nxt;
			pin_change_group_flag_r <= pin_change_group_flag_nxt;
		end
	end

	// =========================================================
	// sleep and wake sequencing

	// asynchronous sources only: enabled pin change or held low level
	assign deep_wake = (|(grp_hit & pin_change_group_enable) &
		global_irq_en) | (ext_en & global_irq_en & ext_level_req);
	assign startup_done = (startup_cnt_r == '0);

	always_comb begin
		state_nxt       = state_r;
		startup_cnt_nxt = startup_cnt_r;
		case (state_r)
			ST_AWAKE: begin
				if (sleep_cmd) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (idle_mode_r && any_req) begin
					state_nxt = ST_AWAKE;
				end else if (!idle_mode_r && deep_wake) begin
					state_nxt       = ST_STARTUP;
					startup_cnt_nxt = CNT_W'(STARTUP_CYC - 1);
				end
			end
			ST_STARTUP: begin
				if (startup_done) begin
					state_nxt = ST_AWAKE;
				end else begin
					startup_cnt_nxt = startup_cnt_r - 1'b1;
				end
			end
			default: begin
				state_nxt = ST_AWAKE;
			end
		endcase
	end

	// state, mode latch and start-up counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r       <= ST_AWAKE;
			idle_mode_r   <= 1'b0;
			startup_cnt_r <= '0;
		end else begin
			state_r       <= state_nxt;
			startup_cnt_r <= startup_cnt_nxt;
			if (state_r == ST_AWAKE && sleep_cmd) begin
				idle_mode_r <= sleep_idle;
			end
		end
	end

	// wake outcome: divert only if a request still stands at the end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_clk_run_r   <= 1'b1;
			wake_pulse_r   <= 1'b0;
			sleep_resume_r <= 1'b0;
		end else begin
			io_clk_run_r   <= (state_nxt == ST_AWAKE) ||
				(state_nxt == ST_SLEEP && (state_r == ST_SLEEP ?
				idle_mode_r : sleep_idle));
			wake_pulse_r   <= (state_r != ST_AWAKE) &&
				(state_nxt == ST_AWAKE);
			sleep_resume_r <= (state_r != ST_AWAKE) &&
				(state_nxt == ST_AWAKE) && !any_req;
		end
	end

	// =========================================================
	// core-facing request and reset vector

	// no vector is offered while asleep or starting up
	assign irq_out_nxt.pending = any_req && (state_r == ST_AWAKE) &&
		!ack_hit;
	assign irq_out_nxt.index   = sel_idx;
	assign irq_out_nxt.vector  = vec_of(sel_idx);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_out_r     <= '{pending: 1'b0, index: '0, vector: VEC_RESET};
			booted_r      <= 1'b0;
			reset_fetch_r <= 1'b0;
		end else begin
			irq_out_r     <= irq_out_nxt;
			booted_r      <= 1'b1;
			reset_fetch_r <= !booted_r;
		end
	end

	// =========================================================
	// Avalon-MM slave: one wait cycle, then the answer
	assign bus_req  = read | write;
	assign wr_acc   = write & ~waitrequest_r;
	assign wr_lane0 = wr_acc & byteenable[0];

	// read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = '0;
		case (address)
			REG_CTRL:     rd_mux[CTRL_W-1:0] = ctrl_r;
			REG_FLAG:     rd_mux[NUM_GRP:0] =
				{pin_change_group_flag_r, ext_irq_flag_r};
			REG_MASK_LO:  rd_mux[G0_W-1:0] = pin_change_mask_lo_r;
			REG_MASK_MID: rd_mux[G1_W-1:0] = pin_change_mask_mid_r;
			REG_MASK_HI:  rd_mux[G2_W-1:0] = pin_change_mask_hi_r;
			REG_STATUS:   rd_mux[9:0] = {ext_now, io_clk_run_r, state_r,
				irq_out_r.pending, irq_out_r.index};
			default:      rd_mux = '0;
		endcase
	end

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitrequest_r <= 1'b1;
			readdata_r    <= '0;
		end else begin
			waitrequest_r <= !(bus_req && waitrequest_r);
			if (read && waitrequest_r) begin
				readdata_r <= rd_mux;
			end
		end
	end

	// control and mask registers, byte lane zero only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r                <= CTRL_RST;
			pin_change_mask_lo_r  <= MASK_RST[G0_W-1:0];
			pin_change_mask_mid_r <= MASK_RST[G1_W-1:0];
			pin_change_mask_hi_r  <= MASK_RST[G2_W-1:0];
		end else if (wr_lane0) begin
			case (address)
				REG_CTRL:     ctrl_r <= writedata[CTRL_W-1:0];
				REG_MASK_LO:  pin_change_mask_lo_r <= writedata[G0_W-1:0];
				REG_MASK_MID: pin_change_mask_mid_r <= writedata[G1_W-1:0];
				REG_MASK_HI:  pin_change_mask_hi_r <= writedata[G2_W-1:0];
				default:      ctrl_r <= ctrl_r;
			endcase
		end
	end

	// =========================================================
	// outputs
	assign readdata     = readdata_r;
	assign waitrequest  = waitrequest_r;
	assign irq_out      = irq_out_r;
	assign io_clk_run   = io_clk_run_r;
	assign wake_pulse   = wake_pulse_r;
	assign sleep_resume = sleep_resume_r;
	assign reset_fetch  = reset_fetch_r;

endmodule : ext_irq_and_vector_table

`default_nettype wire

// >>> logic/irq_pkg.sv
// Purpose: shared constants and types for the external interrupt block
// Assumes: 25 MHz clock, byte-addressed Avalon-MM register window
// Notes:   vector addresses are program word addresses, two words apart
package irq_pkg;

	// =========================================================
	// vector table
	localparam int unsigned NUM_VEC    = 28;
	localparam int unsigned IDX_W      = 5;
	localparam int unsigned VEC_W      = 16;
	localparam int unsigned VEC_STEP   = 2;
	localparam logic [15:0] VEC_RESET  = 16'h0000;
	localparam int unsigned IDX_EXT    = 1;
	localparam int unsigned IDX_GRP0   = 2;
	localparam int unsigned NUM_GRP    = 3;
	localparam int unsigned IDX_PERIPH = 5;
	localparam int unsigned NUM_PERIPH = 23;

	// =========================================================
	// pin change inputs and their groups
	localparam int unsigned NUM_PC  = 18;
	localparam int unsigned G0_LO   = 0;
	localparam int unsigned G0_W    = 8;
	localparam int unsigned G1_LO   = 8;
	localparam int unsigned G1_W    = 4;
	localparam int unsigned G2_LO   = 12;
	localparam int unsigned G2_W    = 6;

	// =========================================================
	// register map (byte addresses) and field positions
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_FLAG     = 8'h04;
	localparam logic [7:0] REG_MASK_LO  = 8'h08;
	localparam logic [7:0] REG_MASK_MID = 8'h0c;
	localparam logic [7:0] REG_MASK_HI  = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;
	localparam int unsigned CTRL_W      = 6;
	localparam int unsigned SENSE_POS   = 0;
	localparam int unsigned EXT_EN_POS  = 2;
	localparam int unsigned GRP_EN_POS  = 3;
	localparam int unsigned FLAG_EXT    = 0;
	localparam int unsigned FLAG_GRP    = 1;
	localparam logic [5:0] CTRL_RST     = 6'h00;
	localparam logic [7:0] MASK_RST     = 8'h00;

	// =========================================================
	// wake-up start-up time
	localparam int unsigned STARTUP_NS  = 4000;
	localparam int unsigned CLK_NS      = 40;
	localparam int unsigned STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CNT_W       = $clog2(STARTUP_CYC + 1);

	// =========================================================
	// types
	typedef enum logic [1:0] {
		SENSE_LOW  = 2'b00,
		SENSE_ANY  = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} sense_t;

	typedef enum logic [1:0] {
		ST_AWAKE   = 2'b00,
		ST_SLEEP   = 2'b01,
		ST_STARTUP = 2'b11
	} pwr_state_t;

	typedef struct packed {
		logic             pending;
		logic [IDX_W-1:0] index;
		logic [VEC_W-1:0] vector;
	} irq_out_t;

endpackage : irq_pkg

// >>> tb/ext_irq_props.sv
// Purpose: concurrent checks on the external interrupt block ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the design top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ext_irq_props (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              read,
	input wire logic              write,
	input wire logic              waitrequest,
	input wire logic              irq_ack,
	input wire logic              sleep_cmd,
	input wire logic              sleep_idle,
	input wire irq_pkg::irq_out_t irq_out,
	input wire logic              io_clk_run,
	input wire logic              wake_pulse,
	input wire logic              sleep_resume,
	input wire logic              reset_fetch
);
	import irq_pkg::*;
	// ========
	// helper: cycles spent with the I/O clock stopped, saturating
	logic [7:0] low_cnt_r;
	always_ff @(posedge clk) begin
		if (!rst_n || io_clk_run)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hff)
			low_cnt_r <= low_cnt_r + 8'h01;
	end
	// ========
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_fetch_vec;
		$rose(rst_n) |=> reset_fetch && irq_out.vector == VEC_RESET;
	endproperty
	a_fetch_vec: assert property (p_fetch_vec)
		else $error("reset fetch missing");
	property p_fetch_once;
		reset_fetch |=> !reset_fetch;
	endproperty
	a_fetch_once: assert property (p_fetch_once)
		else $error("reset fetch too long");
	property p_vec_step;
		irq_out.pending |-> irq_out.vector == 16'({irq_out.index, 1'b0});
	endproperty
	a_vec_step: assert property (p_vec_step)
		else $error("vector not two words per index");
	property p_grp_ack;
		irq_ack && irq_out.pending && irq_out.index >= IDX_GRP0
			&& irq_out.index < IDX_GRP0 + NUM_GRP
		|=> !(irq_out.pending && irq_out.index == $past(irq_out.index));
	endproperty
	a_grp_ack: assert property (p_grp_ack)
		else $error("group flag kept after ack");
	property p_bus_wait;
		(read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait)
		else $error("bus answer late");
	property p_bus_low;
		!waitrequest |=> waitrequest;
	endproperty
	a_bus_low: assert property (p_bus_low)
		else $error("waitrequest low too long");
	property p_deep_sleep;
		sleep_cmd && !sleep_idle |-> ##[1:2] !io_clk_run;
	endproperty
	a_deep_sleep: assert property (p_deep_sleep)
		else $error("clock kept in deep sleep");
	property p_idle_run;
		sleep_cmd && sleep_idle |=> io_clk_run [*4];
	endproperty
	a_idle_run: assert property (p_idle_run)
		else $error("clock stopped in idle");
	property p_startup;
		$rose(io_clk_run) |-> low_cnt_r >= 8'(STARTUP_CYC);
	endproperty
	a_startup: assert property (p_startup)
		else $error("start-up too short");
	property p_resume;
		sleep_resume |-> wake_pulse && io_clk_run ##1 !wake_pulse;
	endproperty
	a_resume: assert property (p_resume)
		else $error("resume without single wake");
endmodule : ext_irq_props

bind ext_irq_and_vector_table ext_irq_props chk_u (
	.clk(clk), .rst_n(rst_n), .read(read), .write(write),
	.waitrequest(waitrequest), .irq_ack(irq_ack), .sleep_cmd(sleep_cmd),
	.sleep_idle(sleep_idle), .irq_out(irq_out), .io_clk_run(io_clk_run),
	.wake_pulse(wake_pulse), .sleep_resume(sleep_resume),
	.reset_fetch(reset_fetch)
);
`default_nettype wire

// >>> tb/core_model.sv
// Purpose: processor core stand-in that takes presented vectors
// Assumes: ack is one pulse, raised only while a vector is pending
// Notes:   slow mode lets a request stand four cycles before the ack
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire irq_pkg::irq_out_t irq_out,
	input  wire logic              slow,
	output logic                   irq_ack,
	output logic [15:0]            last_vec,
	output logic [15:0]            take_cnt
);
	import irq_pkg::*;
	logic [1:0] wait_r;
	// ack a pending vector, record it at the edge that takes it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_ack <= 1'b0;
			wait_r <= 2'h0;
			last_vec <= 16'h0000;
			take_cnt <= 16'h0000;
		end else begin
			wait_r <= !irq_out.pending ? 2'h0 : wait_r + 2'(wait_r != 2'h3);
			irq_ack <= irq_out.pending && !irq_ack && (!slow || wait_r == 2'h3);
			if (irq_ack && irq_out.pending) begin
				last_vec <= irq_out.vector;
				take_cnt <= take_cnt + 16'h0001;
			end
		end
	end
endmodule : core_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the external interrupt block
// Assumes: core model acks every vector the block presents
// Notes:   pins are driven directly, as a port driving its own pin would
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import irq_pkg::*;
	logic                  clk;
	logic                  rst_n;
	logic [7:0]            address;
	logic                  read;
	logic                  write;
	logic [31:0]           writedata;
	logic [3:0]            byteenable;
	logic [31:0]           readdata;
	logic                  waitrequest;
	logic                  ext_irq_pin;
	logic [NUM_PC-1:0]     pin_change_input;
	logic [NUM_PERIPH-1:0] periph_irq;
	logic                  global_irq_en;
	logic                  irq_ack;
	logic                  sleep_cmd;
	logic                  sleep_idle;
	logic                  slow;
	irq_out_t              irq_out;
	logic                  io_clk_run;
	logic                  wake_pulse;
	logic                  sleep_resume;
	logic                  reset_fetch;
	logic [15:0]           last_vec;
	logic [15:0]           take_cnt;
	int                    bad_count = 0;
	int                    checks_done = 0;
	int                    cyc = 0;

	ext_irq_and_vector_table dut_u (
		.clk(clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.ext_irq_pin(ext_irq_pin), .pin_change_input(pin_change_input),
		.periph_irq(periph_irq), .global_irq_en(global_irq_en),
		.irq_ack(irq_ack), .sleep_cmd(sleep_cmd), .sleep_idle(sleep_idle),
		.irq_out(irq_out), .io_clk_run(io_clk_run),
		.wake_pulse(wake_pulse), .sleep_resume(sleep_resume),
		.reset_fetch(reset_fetch)
	);
	core_model core_u (
		.clk(clk), .rst_n(rst_n), .irq_out(irq_out), .slow(slow),
		.irq_ack(irq_ack), .last_vec(last_vec), .take_cnt(take_cnt)
	);

	// ========
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			$display("[ERR] %0t run hung", $time);
			summarize();
		end
	end

	// ========
	// helpers
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		chk(32'(n < 50), 32'h1, "bus hang");
	endtask : bus
	task automatic take(input logic [15:0] c0, e, input string m);
		int n;
		n = 0;
		while (take_cnt === c0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n < 400), 32'h1, "no vector taken");
		chk(32'(last_vec), 32'(e), m);
	endtask : take
	task automatic none(input int k);
		logic [15:0] c0;
		c0 = take_cnt;
		repeat (k) @(posedge clk);
		chk(32'(take_cnt), 32'(c0), "unexpected vector");
	endtask : none
	task automatic nap(input logic idle);
		@(posedge clk);
		sleep_cmd <= 1'b1;
		sleep_idle <= idle;
		@(posedge clk);
		sleep_cmd <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(io_clk_run), 32'(idle), "io clock in sleep");
	endtask : nap
	task automatic wake(input logic exp);
		int n;
		n = 0;
		while (wake_pulse !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n < 400), 32'h1, "no wake");
		chk(32'(sleep_resume), 32'(exp), "resume flag");
	endtask : wake

	// ========
	// scenarios
	task automatic t_regs();
		logic [31:0] q;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, REG_CTRL + 8'(4 * i), 32'h0, q);
			chk(q, 32'(MASK_RST), "reset value");
		end
		bus(1'b0, REG_STATUS, 32'h0, q);
		chk(q, 32'h300, "status idle");
		bus(1'b1, REG_CTRL, 32'hffff_ffea, q);
		bus(1'b0, REG_CTRL, 32'h0, q);
		chk(q, 32'h2a, "ctrl readback");
		@(posedge clk) byteenable <= 4'h0;
		bus(1'b1, REG_CTRL, 32'h0, q);
		@(posedge clk) byteenable <= 4'h1;
		bus(1'b0, REG_CTRL, 32'h0, q);
		chk(q, 32'h2a, "lane off write");
		bus(1'b1, 8'h18, 32'hff, q);
		bus(1'b0, 8'h18, 32'h0, q);
		chk(q, 32'h0, "unmapped read");
		bus(1'b1, REG_CTRL, 32'h0, q);
	endtask : t_regs
	task automatic t_vec();
		logic [15:0] c0;
		@(posedge clk) slow <= 1'b1;
		for (int k = 0; k < NUM_PERIPH; k++) begin
			c0 = take_cnt;
			@(posedge clk) periph_irq <= NUM_PERIPH'(1) << k;
			take(c0, 16'(VEC_STEP * (IDX_PERIPH + k)), "periph vec");
			@(posedge clk) periph_irq <= '0;
			repeat (6) @(posedge clk);
		end
		chk(32'(last_vec), 32'h36, "last vector");
		c0 = take_cnt;
		@(posedge clk) periph_irq <= '1;
		take(c0, 16'h000a, "lowest index");
		@(posedge clk) periph_irq <= '0;
		slow <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : t_vec
	task automatic t_pc();
		logic [31:0] q;
		logic [15:0] c0;
		int          g;
		bus(1'b1, REG_MASK_LO, 32'hff, q);
		bus(1'b1, REG_MASK_MID, 32'h0f, q);
		bus(1'b1, REG_MASK_HI, 32'h3f, q);
		bus(1'b1, REG_CTRL, 32'h38, q);
		bus(1'b1, REG_FLAG, 32'h0f, q);
		for (int p = 0; p < NUM_PC; p++) begin
			g = p < G1_LO ? 0 : p < G2_LO ? 1 : 2;
			c0 = take_cnt;
			@(posedge clk) pin_change_input[p] <= ~pin_change_input[p];
			take(c0, 16'(2 * (IDX_GRP0 + g)), "group vec");
		end
		bus(1'b1, REG_MASK_LO, 32'hfe, q);
		@(posedge clk) pin_change_input[0] <= ~pin_change_input[0];
		none(20);
		bus(1'b0, REG_FLAG, 32'h0, q);
		chk(q, 32'h0, "masked pin flag");
		@(posedge clk) global_irq_en <= 1'b0;
		@(posedge clk) pin_change_input[9] <= ~pin_change_input[9];
		none(20);
		bus(1'b0, REG_FLAG, 32'h0, q);
		chk(q, 32'h4, "group flag set");
		bus(1'b1, REG_FLAG, 32'h4, q);
		bus(1'b0, REG_FLAG, 32'h0, q);
		chk(q, 32'h0, "group flag clear");
		@(posedge clk) global_irq_en <= 1'b1;
	endtask : t_pc
	task automatic t_ext();
		logic [31:0] q;
		logic [15:0] c0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, REG_CTRL, 32'h4 | 32'(i), q);
			bus(1'b1, REG_FLAG, 32'h0f, q);
			c0 = take_cnt;
			@(posedge clk) ext_irq_pin <= 1'b0;
			if (sense_t'(i) == SENSE_LOW) begin
				repeat (40) @(posedge clk);
				chk(32'(take_cnt - c0 > 16'd3), 32'h1, "level repeat");
				bus(1'b0, REG_FLAG, 32'h0, q);
				chk(q & 32'h1, 32'h0, "level flag");
				@(posedge clk) ext_irq_pin <= 1'b1;
				repeat (8) @(posedge clk);
				none(20);
			end else begin
				if (sense_t'(i) != SENSE_RISE) take(c0, 16'h0002, "fall");
				else none(20);
				c0 = take_cnt;
				@(posedge clk) ext_irq_pin <= 1'b1;
				if (sense_t'(i) != SENSE_FALL) take(c0, 16'h0002, "rise");
				else none(20);
			end
		end
	endtask : t_ext
	task automatic t_sleep();
		logic [31:0] q;
		logic [15:0] c0;
		bus(1'b1, REG_CTRL, 32'h3f, q);
		bus(1'b1, REG_FLAG, 32'h0f, q);
		nap(1'b0);
		@(posedge clk) ext_irq_pin <= 1'b0;
		repeat (6) @(posedge clk);
		@(posedge clk) ext_irq_pin <= 1'b1;
		repeat (10) @(posedge clk);
		chk(32'(io_clk_run), 32'h0, "edge woke part");
		c0 = take_cnt;
		@(posedge clk) pin_change_input[12] <= ~pin_change_input[12];
		wake(1'b0);
		take(c0, 16'h0008, "pin wake vec");
		none(20);
		bus(1'b1, REG_CTRL, 32'h04, q);
		nap(1'b0);
		c0 = take_cnt;
		@(posedge clk) ext_irq_pin <= 1'b0;
		repeat (10) @(posedge clk);
		@(posedge clk) ext_irq_pin <= 1'b1;
		wake(1'b1);
		none(20);
		nap(1'b0);
		c0 = take_cnt;
		@(posedge clk) ext_irq_pin <= 1'b0;
		wake(1'b0);
		take(c0, 16'h0002, "level wake vec");
		@(posedge clk) ext_irq_pin <= 1'b1;
		repeat (8) @(posedge clk);
		bus(1'b1, REG_CTRL, 32'h20, q);
		nap(1'b1);
		c0 = take_cnt;
		@(posedge clk) pin_change_input[12] <= ~pin_change_input[12];
		wake(1'b0);
		take(c0, 16'h0008, "idle wake vec");
	endtask : t_sleep
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// ========
	// main sequence
	initial begin
		rst_n = 1'b0;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h1;
		ext_irq_pin = 1'b1;
		pin_change_input = '0;
		periph_irq = '0;
		global_irq_en = 1'b1;
		sleep_cmd = 1'b0;
		sleep_idle = 1'b0;
		slow = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		$display("test regs done");
		t_vec();
		$display("test vectors done");
		t_pc();
		$display("test pin change done");
		t_ext();
		$display("test ext pin done");
		t_sleep();
		$display("test sleep done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
